//--- include/cfg_load_pkg.sv
// Constants and carriers for the parallel configuration load sequencer.
// Assumes a 100 MHz main clock; the load clock is a separate domain.
`default_nettype none
package cfg_load_pkg;
	localparam int unsigned MCLK_MHZ        = 100;
	localparam int unsigned RESTART_LOW_NS  = 600;
	localparam int unsigned STATUS_MIN_US   = 268;
	localparam int unsigned STATUS_MAX_US   = 1506;
	localparam int unsigned UM_MIN_US       = 175;
	localparam int unsigned UM_MAX_US       = 437;
	localparam int unsigned INIT_CYCLES     = 17408;
	localparam int unsigned USR_EN_PERIODS  = 4;
	// Times in ns convert to cycles by integer division, so any remainder rounds down
	localparam int unsigned RESTART_LOW_CYC =
		(RESTART_LOW_NS * MCLK_MHZ) / 1000;
	localparam int unsigned STATUS_MIN_CYC  = STATUS_MIN_US * MCLK_MHZ;
	localparam int unsigned STATUS_MAX_CYC  = STATUS_MAX_US * MCLK_MHZ;
	localparam int unsigned UM_MIN_CYC      = UM_MIN_US * MCLK_MHZ;
	localparam int unsigned UM_MAX_CYC      = UM_MAX_US * MCLK_MHZ;
	localparam int unsigned CNT_W           = 24;
	localparam logic [1:0]  RATIO_ONE       = 2'h0;
	localparam logic [1:0]  RATIO_TWO       = 2'h1;
	localparam logic [1:0]  RATIO_FOUR      = 2'h3;

	typedef enum {
		ST_RESET, ST_STATUS_LOW, ST_LOAD, ST_INIT, ST_USER
	} seq_state_type;

	typedef struct packed {
		logic wide_mode;
		logic encrypt_on;
		logic compress_on;
		logic init_on_user_clock;
	} load_cfg_type;

	typedef struct packed {
		logic [15:0] data;
		logic        valid;
	} load_word_type;
endpackage
`default_nettype wire

//--- logic/parallel_config_load_sequencer.sv
// Device-side sequencer for a parallel configuration image load.
// Assumes restart_n, status_in_n and load_done are asynchronous pins.
`default_nettype none
module parallel_config_load_sequencer #(
	parameter int unsigned STATUS_MIN_CYC = cfg_load_pkg::STATUS_MIN_CYC,
	parameter int unsigned UM_MIN_CYC     = cfg_load_pkg::UM_MIN_CYC,
	parameter int unsigned INIT_CYCLES    = cfg_load_pkg::INIT_CYCLES
) (
	input  wire logic                       mclk,
	input  wire logic                       reset_n,
	input  wire logic                       load_clock,
	input  wire logic                       restart_n,
	input  wire logic                       status_in_n,
	input  wire logic [15:0]                load_data,
	input  wire cfg_load_pkg::load_cfg_type cfg,
	input  wire logic                       load_done,
	input  wire logic                       init_user_clock,
	output logic                            status_out_n,
	output logic                            status_oe_n,
	output logic                            done_out,
	output logic                            done_oe_n,
	output cfg_load_pkg::load_word_type     word_out,
	output logic                            user_mode
);
	// Ratio select from width and features
	function automatic logic [1:0] ratio_mask(
		input cfg_load_pkg::load_cfg_type c);
		if (c.compress_on)
			ratio_mask = c.wide_mode ? cfg_load_pkg::RATIO_FOUR
				: cfg_load_pkg::RATIO_TWO;
		else if (c.wide_mode && c.encrypt_on)
			ratio_mask = cfg_load_pkg::RATIO_TWO;
		else
			ratio_mask = cfg_load_pkg::RATIO_ONE;
	endfunction

	// One step of a two-stage synchroniser
	function automatic logic [1:0] sync2(input logic [1:0] q,
		input logic d);
		sync2 = {q[0], d};
	endfunction

	// Counter load from a cycle count; top bits cut on purpose
	function automatic logic [cfg_load_pkg::CNT_W-1:0] to_cnt(
		input int unsigned v);
		to_cnt = v[cfg_load_pkg::CNT_W-1:0];
	endfunction

	// Status pulled from reset until the low time has run out
	function automatic logic pulls_status(
		input cfg_load_pkg::seq_state_type s);
		unique case (s)
			cfg_load_pkg::ST_RESET, cfg_load_pkg::ST_STATUS_LOW:
				pulls_status = 1'b1;
			cfg_load_pkg::ST_LOAD, cfg_load_pkg::ST_INIT,
			cfg_load_pkg::ST_USER:
				pulls_status = 1'b0;
		endcase
	endfunction

	// Completion stays pulled until the image is in
	function automatic logic pulls_done(
		input cfg_load_pkg::seq_state_type s);
		unique case (s)
			cfg_load_pkg::ST_RESET, cfg_load_pkg::ST_STATUS_LOW,
			cfg_load_pkg::ST_LOAD:
				pulls_done = 1'b1;
			cfg_load_pkg::ST_INIT, cfg_load_pkg::ST_USER:
				pulls_done = 1'b0;
		endcase
	endfunction

	typedef struct packed {
		cfg_load_pkg::seq_state_type state;
		logic [cfg_load_pkg::CNT_W-1:0] cnt;
		logic [1:0] rst_sync;
		logic [1:0] st_sync;
		logic [1:0] done_sync;
		logic [1:0] uclk_sync;
		logic       uclk_prev;
		logic [1:0] act_sync;
		logic [1:0] tog_sync;
		logic       tog_seen;
		cfg_load_pkg::load_word_type word;
	} main_state_type;

	typedef struct packed {
		logic [1:0]  phase;
		logic [15:0] data;
		logic        tog;
	} link_state_type;

	main_state_type main_ff, nxt_main;
	link_state_type link_ff, nxt_link;
	logic           load_active;
	logic           word_ready;

	assign load_active = (main_ff.state == cfg_load_pkg::ST_LOAD);
	// Link data is read only after the toggle has settled here;
	// the host holds each word far longer than the sync takes
	assign word_ready  = (main_ff.tog_sync[1] != main_ff.tog_seen);

	// Link domain: one capture per group, rest only process
	always_comb begin
		nxt_link = link_ff;
		if (!main_ff.act_sync[1]) begin
			nxt_link.phase = 2'h0;
		end else begin
			if (link_ff.phase == 2'h0) begin
				nxt_link.data = load_data;
				nxt_link.tog  = ~link_ff.tog;
			end
			nxt_link.phase = (link_ff.phase + 2'h1)
				& ratio_mask(cfg);
		end
	end

	// Clock runs only during frames; phase reset via synced level
	always_ff @(posedge load_clock or negedge reset_n) begin
		if (!reset_n) begin
			link_ff <= '0;
		end else begin
			link_ff <= nxt_link;
		end
	end

	// Main domain
	always_comb begin
		logic rst_low;
		logic uclk_rise;
		rst_low = 1'b0;
		uclk_rise = 1'b0;
		nxt_main = main_ff;
		nxt_main.rst_sync  = sync2(main_ff.rst_sync, restart_n);
		nxt_main.st_sync   = sync2(main_ff.st_sync, status_in_n);
		nxt_main.done_sync = sync2(main_ff.done_sync, load_done);
		nxt_main.uclk_sync = sync2(main_ff.uclk_sync, init_user_clock);
		nxt_main.uclk_prev = main_ff.uclk_sync[1];
		nxt_main.act_sync  = sync2(main_ff.act_sync, load_active);
		nxt_main.tog_sync  = sync2(main_ff.tog_sync, link_ff.tog);
		nxt_main.tog_seen  = main_ff.tog_sync[1];
		nxt_main.word.valid = 1'b0;
		rst_low   = !main_ff.rst_sync[1];
		uclk_rise = main_ff.uclk_sync[1] && !main_ff.uclk_prev;
		if (word_ready) begin
			nxt_main.word.data  = link_ff.data;
			nxt_main.word.valid = 1'b1;
		end
		if (main_ff.cnt != '0)
			nxt_main.cnt = main_ff.cnt - 1'b1;
		// Restart wins over every state; outputs fall in 3 cycles
		if (rst_low) begin
			nxt_main.state = cfg_load_pkg::ST_STATUS_LOW;
			nxt_main.cnt = to_cnt(STATUS_MIN_CYC);
		end else begin
			unique case (main_ff.state)
				cfg_load_pkg::ST_RESET:
					nxt_main.state = cfg_load_pkg::ST_LOAD;
				cfg_load_pkg::ST_STATUS_LOW: begin
					if (main_ff.cnt == '0)
						nxt_main.state = cfg_load_pkg::ST_LOAD;
				end
				cfg_load_pkg::ST_LOAD: begin
					// Hold off while something outside pulls status low
					if (main_ff.st_sync[1] && main_ff.done_sync[1]) begin
						nxt_main.state = cfg_load_pkg::ST_INIT;
						nxt_main.cnt = cfg.init_on_user_clock
							? to_cnt(INIT_CYCLES)
							: to_cnt(UM_MIN_CYC);
					end
				end
				cfg_load_pkg::ST_INIT: begin
					// User clock rising edges are counted, not the oscillator
					if (cfg.init_on_user_clock) begin
						nxt_main.cnt = main_ff.cnt;
						if (uclk_rise && main_ff.cnt != '0)
							nxt_main.cnt = main_ff.cnt - 1'b1;
					end
					if (main_ff.cnt == '0)
						nxt_main.state = cfg_load_pkg::ST_USER;
				end
				cfg_load_pkg::ST_USER:
					nxt_main.state = cfg_load_pkg::ST_USER;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			main_ff <= '0;
		end else begin
			main_ff <= nxt_main;
		end
	end

	// Open-drain style: enable low drives the pin low
	assign status_out_n = 1'b0;
	assign status_oe_n  = !pulls_status(main_ff.state);
	assign done_out     = 1'b0;
	assign done_oe_n    = !pulls_done(main_ff.state);
	assign word_out     = main_ff.word;
	assign user_mode    = (main_ff.state == cfg_load_pkg::ST_USER);
endmodule // parallel_config_load_sequencer
`default_nettype wire

//--- tb/cfg_load_chk.sv
// Checker: status, completion, word and user mode timing at the pins.
// Assumes binding into the sequencer; one mclk domain.
`default_nettype none
module cfg_load_chk #(
	parameter int unsigned STATUS_MIN_CYC = 50,
	parameter int unsigned UM_MIN_CYC     = 40,
	parameter int unsigned INIT_CYCLES    = 8
) (
	input wire logic                        mclk,
	input wire logic                        reset_n,
	input wire logic                        restart_n,
	input wire cfg_load_pkg::load_cfg_type  cfg,
	input wire logic                        status_oe_n,
	input wire logic                        done_oe_n,
	input wire cfg_load_pkg::load_word_type word_out,
	input wire logic                        user_mode
);
	logic [23:0] low_ff;
	logic [23:0] init_ff;
	// Status low count starts from a restart only, so reset release is never judged
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			low_ff  <= 24'h0;
			init_ff <= 24'h0;
		end else begin
			if (!restart_n)
				low_ff <= 24'h1;
			else if (low_ff != 24'h0 && !status_oe_n)
				low_ff <= low_ff + 24'h1;
			else
				low_ff <= 24'h0;
			init_ff <= (done_oe_n && !user_mode) ? init_ff + 24'h1 : 24'h0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	AST_CD_LOW: assert property (
		$fell(restart_n) |-> ##[1:60] !done_oe_n) else $error("cd late");
	AST_ST_LOW: assert property (
		$fell(restart_n) |-> ##[1:60] !status_oe_n) else $error("st late");
	AST_ST_MIN: assert property (
		$rose(status_oe_n) && low_ff != 24'h0 |-> low_ff >= STATUS_MIN_CYC)
		else $error("status short");
	AST_ST_MAX: assert property (
		low_ff < cfg_load_pkg::STATUS_MAX_CYC) else $error("status long");
	AST_UM_MIN: assert property (
		$rose(user_mode) && !cfg.init_on_user_clock |-> init_ff >= UM_MIN_CYC)
		else $error("user mode early");
	AST_UM_INIT: assert property (
		$rose(user_mode) |-> done_oe_n && init_ff >= INIT_CYCLES)
		else $error("init short");
	AST_WD_ONE: assert property (
		word_out.valid |=> !word_out.valid) else $error("word twice");
	AST_WD_LOAD: assert property (
		word_out.valid |-> status_oe_n && !done_oe_n) else $error("stray word");
endmodule // cfg_load_chk
bind parallel_config_load_sequencer cfg_load_chk #(
	.STATUS_MIN_CYC(STATUS_MIN_CYC), .UM_MIN_CYC(UM_MIN_CYC),
	.INIT_CYCLES(INIT_CYCLES)
) chk (
	.mclk(mclk), .reset_n(reset_n), .restart_n(restart_n), .cfg(cfg),
	.status_oe_n(status_oe_n), .done_oe_n(done_oe_n),
	.word_out(word_out), .user_mode(user_mode)
);
`default_nettype wire

//--- tb/cfg_host_model.sv
// Host model: clocks image words into the parallel load port.
// Assumes the bench calls send only while the device loads.
`default_nettype none
module cfg_host_model (
	output var logic        load_clock,
	output var logic [15:0] load_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		load_clock = 1'b0;
		load_data  = 16'h0000;
	end
	// Clock stands still between frames; gap models a slow host
	task automatic send(input logic [15:0] base, input int n, input int r,
		input int gap);
		for (int k = 0; k < n; k++) begin
			load_data <= base + 16'(k) * 16'h0101;
			for (int e = 0; e < r; e++) begin
				#20 load_clock <= 1'b1;
				#40 load_clock <= 1'b0;
				#20;
			end
			#(gap);
		end
		load_data <= ~load_data;
	endtask
endmodule // cfg_host_model
`default_nettype wire

//--- tb/parallel_config_load_sequencer_test.sv
// Bench: restart, status, eight option rows, both init clock sources.
// Assumes the bound checker and the host model beside the design.
`default_nettype none
module parallel_config_load_sequencer_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic                        mclk, reset_n, restart_n, load_done;
	logic                        init_user_clock, load_clock, user_mode;
	logic                        status_oe_n, done_oe_n;
	logic [15:0]                 load_data, base;
	cfg_load_pkg::load_cfg_type  cfg;
	cfg_load_pkg::load_word_type word_out;
	int                          failures, samples_checked, got, n, r;
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	cfg_host_model host (.load_clock(load_clock), .load_data(load_data));
	// Status wire has a pull-up and only the device pulls it
	parallel_config_load_sequencer #(.STATUS_MIN_CYC(50), .UM_MIN_CYC(40),
		.INIT_CYCLES(8)) DUT (.mclk(mclk), .reset_n(reset_n),
		.load_clock(load_clock), .restart_n(restart_n),
		.status_in_n(status_oe_n), .load_data(load_data), .cfg(cfg),
		.load_done(load_done), .init_user_clock(init_user_clock),
		.status_out_n(), .status_oe_n(status_oe_n), .done_out(),
		.done_oe_n(done_oe_n), .word_out(word_out), .user_mode(user_mode));
	task automatic check(input logic ok, input string m);
		samples_checked++;
		if (!ok) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic results();
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bound(input int lim);
		if (n >= lim) begin
			check(1'b0, "timeout");
			results();
		end
	endtask
	always @(negedge mclk) if (word_out.valid === 1'b1) begin
		check(word_out.data === base + 16'(got) * 16'h0101, "word");
		got++;
	end
	initial begin
		{reset_n, restart_n, load_done, init_user_clock} = 4'h4;
		cfg = 4'h0;
		base = 16'h0000;
		repeat (16) @(posedge mclk);
		check(status_oe_n === 1'b0 && user_mode === 1'b0, "reset");
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			cfg <= {i[2], i[1], i[0], i[2] ^ i[0]};
			restart_n <= 1'b0;
			load_done <= 1'b0;
			repeat (60) @(negedge mclk);
			check(status_oe_n === 1'b0 && done_oe_n === 1'b0, "pins");
			repeat (140) @(posedge mclk);
			restart_n <= 1'b1;
			for (n = 0; n < 2000 && status_oe_n !== 1'b1; n++) @(negedge mclk);
			bound(2000);
			check(n >= 50, "status short");
			repeat (200) @(posedge mclk);
			r = i[2] ? (i[0] ? 4 : i[1] ? 2 : 1) : (i[0] ? 2 : 1);
			base = 16'h1000 * 16'(i) + 16'h0A5C;
			got = 0;
			host.send(base, 3, r, 10 * i);
			repeat (10) @(posedge mclk);
			check(got == 3, "word count");
			load_done <= 1'b1;
			if (cfg.init_on_user_clock) begin
				repeat (32) @(posedge mclk);
				for (n = 0; n < 100 && user_mode !== 1'b1; n++) begin
					repeat (2) @(posedge mclk);
					init_user_clock <= ~init_user_clock;
					@(negedge mclk);
				end
				bound(100);
				check(n >= 16, "user clock");
			end else begin
				for (n = 0; n < 1000 && user_mode !== 1'b1; n++) @(negedge mclk);
				bound(1000);
				check(n >= 40, "oscillator");
			end
			$display("test %0d done", i);
		end
		results();
	end
endmodule // parallel_config_load_sequencer_test
`default_nettype wire
